// ===== shared/iwdt_pkg.sv
// iwdt_pkg: constants and types of the indexed-port watchdog
// assumes one 250 MHz clock and a host io strobe already in that domain
package iwdt_pkg;

  // -------------------------------------------------------------
  // host io ports and configuration keys
  // -------------------------------------------------------------
  localparam logic [15:0] IWDT_INDEX_PORT = 16'h002E; // register select
  localparam logic [15:0] IWDT_DATA_PORT  = 16'h002F; // register data
  localparam logic [7:0]  IWDT_KEY_UNLOCK = 8'h87;    // written twice
  localparam logic [7:0]  IWDT_KEY_LOCK   = 8'hAA;    // ends session

  // -------------------------------------------------------------
  // register indexes and values
  // -------------------------------------------------------------
  localparam logic [7:0] IWDT_IDX_DEV_SELECT = 8'h07; // logical_device_select
  localparam logic [7:0] IWDT_IDX_ACTIVATE   = 8'h30; // function_activate
  localparam logic [7:0] IWDT_IDX_UNIT       = 8'hF5; // count_unit_config
  localparam logic [7:0] IWDT_IDX_COUNT      = 8'hF6; // timeout_count
  localparam logic [7:0] IWDT_IDX_CTRL       = 8'hF7; // control_and_status
  localparam logic [7:0] IWDT_DEV_WDT        = 8'h08; // watchdog bank
  localparam logic [7:0] IWDT_ZERO8          = 8'h00; // reset / stopped
  localparam logic [7:0] IWDT_ONE8           = 8'h01; // last unit
  localparam logic [7:0] IWDT_READ_IDLE      = 8'hFF; // floating bus read

  // -------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------
  localparam int IWDT_ACT_BIT   = 0; // function enable
  localparam int IWDT_UNIT_BIT  = 3; // 1 = minutes
  localparam int IWDT_STAT_BIT  = 4; // timed out
  localparam int IWDT_FORCE_BIT = 5; // force timeout, self clearing
  localparam int IWDT_KBD_BIT   = 6; // keyboard restarts
  localparam int IWDT_MOUSE_BIT = 7; // mouse restarts

  // -------------------------------------------------------------
  // timing
  // -------------------------------------------------------------
  localparam int unsigned IWDT_CLK_HZ     = 250_000_000; // clk rate
  localparam int unsigned IWDT_UNIT_SEC_S = 1;           // base unit, s
  localparam int unsigned IWDT_SEC_CYC    = IWDT_CLK_HZ * IWDT_UNIT_SEC_S;
  localparam int          IWDT_DIV_W      = 28;          // holds SEC_CYC
  localparam logic [5:0]  IWDT_SEC_PER_MIN = 6'h3C;      // 60 s
  localparam logic [1:0]  IWDT_STRAP_WAIT  = 2'h2;       // sync fill

  // -------------------------------------------------------------
  // types
  // -------------------------------------------------------------
  typedef enum logic [2:0] {
    IWDT_LOCKED   = 3'b001,
    IWDT_KEY_ONE  = 3'b010,
    IWDT_UNLOCKED = 3'b100
  } iwdt_cfg_t;

  typedef struct packed {
    logic [15:0] addr;  // io address
    logic        wr;    // one-cycle write strobe
    logic        rd;    // one-cycle read strobe
    logic [7:0]  wdata; // write data
  } iwdt_io_req_t;

  typedef struct packed {
    logic [IWDT_DIV_W-1:0] div;  // cycles within a second
    logic [5:0]            secs; // seconds within a minute
    logic                  tick; // one unit elapsed
  } iwdt_tick_st_t;

endpackage

// ===== src/iwdt_unit_tick.sv
// iwdt_unit_tick: one-cycle pulse per second or per minute
// assumes clk at IWDT_CLK_HZ; run and restart come from the same clock
`timescale 1ns/1ns
module iwdt_unit_tick #(
  parameter int unsigned CYC_PER_SEC = iwdt_pkg::IWDT_SEC_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic ce,
  // control
  input  wire logic run,      // count while high
  input  wire logic restart,  // clear the prescaler
  input  wire logic unit_min, // minutes instead of seconds
  // result
  output logic      tick      // one unit elapsed
);
  import iwdt_pkg::*;

  iwdt_tick_st_t r_reg; // all state
  iwdt_tick_st_t r_next; // next state

  // -------------------------------------------------------------
  // prescaler
  // -------------------------------------------------------------
  // restart clears the partial unit so a reload gets its full time
  always_comb begin
    r_next      = r_reg;
    r_next.tick = 1'b0;
    if (restart || !run) begin
      r_next.div  = '0;
      r_next.secs = '0;
    end else if (r_reg.div == IWDT_DIV_W'(CYC_PER_SEC - 1)) begin
      r_next.div = '0;
      if (!unit_min) begin
        r_next.tick = 1'b1;
      end else if (r_reg.secs == IWDT_SEC_PER_MIN - 6'h01) begin
        r_next.secs = '0;
        r_next.tick = 1'b1;
      end else begin
        r_next.secs = r_reg.secs + 6'h01;
      end
    end else begin
      r_next.div = r_reg.div + IWDT_DIV_W'(1);
    end
  end

  // state register, frozen while ce is low
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_reg <= '0;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  assign tick = r_reg.tick;

endmodule // iwdt_unit_tick

// ===== src/iwdt_top.sv
// iwdt_top: watchdog reached through an index/data io port pair
// assumes the host io strobes are synchronous one-cycle pulses on clk;
// keyboard, mouse and strap pins are asynchronous and synchronised here
`timescale 1ns/1ns

module iwdt_top #(
  parameter int unsigned CYC_PER_SEC = iwdt_pkg::IWDT_SEC_CYC
) (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic                   ce,
  // host io port
  input  wire iwdt_pkg::iwdt_io_req_t io_req,
  output logic [7:0]                  io_rdata,
  output logic                        io_rvalid,
  // activity and strap pins
  input  wire logic                   kbd_activity,
  input  wire logic                   mouse_activity,
  input  wire logic                   expiry_action_strap,
  // expiry outputs
  output logic                        timeout_irq_n,
  output logic                        timeout_reset
);
  import iwdt_pkg::*;

  // -------------------------------------------------------------
  // state
  // -------------------------------------------------------------
  typedef struct packed {
    iwdt_cfg_t  cfg;        // lock sequence
    logic [7:0] index;      // selected register
    logic [7:0] dev_sel;    // logical device
    logic       active;     // function enabled
    logic       unit_min;   // minutes unit
    logic [7:0] count_set;  // programmed count
    logic [7:0] counter;    // remaining units
    logic       kbd_en;     // keyboard restarts
    logic       mouse_en;   // mouse restarts
    logic       timed_out;  // sticky expiry
    logic [2:0] kbd_s;      // sync + edge delay
    logic [2:0] mouse_s;    // sync + edge delay
    logic [1:0] strap_s;    // strap sync
    logic [1:0] strap_wait; // cycles since release
    logic       strap_done; // strap captured
    logic       strap_irq;  // 1 = interrupt form
    logic [7:0] rdata;      // read answer
    logic       rvalid;     // read answer pulse
    logic       irq_n;      // interrupt pin
    logic       rst_out;    // reset pin
  } iwdt_state_t;

  iwdt_state_t r_reg;  // registered state
  iwdt_state_t r_next; // next state

  logic unit_tick; // one unit elapsed
  logic restart;   // reload request this cycle
  logic run;       // counter running

  // -------------------------------------------------------------
  // decode helpers
  // -------------------------------------------------------------
  // watchdog bank is visible only with the right device selected
  function automatic logic wdt_bank(input logic [7:0] dev);
    return dev == IWDT_DEV_WDT;
  endfunction

  // register read mux; the write-only force field reads back as zero
  function automatic logic [7:0] reg_read(input iwdt_state_t s);
    logic [7:0] v;
    v = IWDT_ZERO8;
    if (s.index == IWDT_IDX_DEV_SELECT) begin
      v = s.dev_sel;
    end else if (wdt_bank(s.dev_sel)) begin
      unique case (s.index)
        IWDT_IDX_ACTIVATE: begin
          v[IWDT_ACT_BIT] = s.active;
        end
        IWDT_IDX_UNIT: begin
          v[IWDT_UNIT_BIT] = s.unit_min;
        end
        IWDT_IDX_COUNT: begin
          v = s.count_set;
        end
        IWDT_IDX_CTRL: begin
          // force bit always reads zero
          v[IWDT_MOUSE_BIT] = s.mouse_en;
          v[IWDT_KBD_BIT]   = s.kbd_en;
          v[IWDT_STAT_BIT]  = s.timed_out;
        end
        default: begin
          v = IWDT_ZERO8; // unmapped index
        end
      endcase
    end
    return v;
  endfunction

  // -------------------------------------------------------------
  // unit prescaler
  // -------------------------------------------------------------
  // stops while disabled, at count zero or once expired
  assign run = r_reg.active && (r_reg.count_set != IWDT_ZERO8)
               && !r_reg.timed_out;

  iwdt_unit_tick #(
    .CYC_PER_SEC (CYC_PER_SEC)
  ) u_tick (
    .clk      (clk),
    .reset    (reset),
    .ce       (ce),
    .run      (run),
    .restart  (restart),
    .unit_min (r_reg.unit_min),
    .tick     (unit_tick)
  );

  // -------------------------------------------------------------
  // next-state logic
  // -------------------------------------------------------------
  always_comb begin
    logic idx_wr;   // write to index port
    logic dat_wr;   // write to data port
    logic idx_rd;   // read of index port
    logic dat_rd;   // read of data port
    logic open_cfg; // configuration unlocked
    logic kbd_evt;  // keyboard activity edge
    logic ms_evt;   // mouse activity edge
    logic force_to; // software forced timeout
    logic cnt_wr;   // count register written
    idx_wr   = 1'b0;
    dat_wr   = 1'b0;
    idx_rd   = 1'b0;
    dat_rd   = 1'b0;
    open_cfg = 1'b0;
    kbd_evt  = 1'b0;
    ms_evt   = 1'b0;
    force_to = 1'b0;
    cnt_wr   = 1'b0;
    restart  = 1'b0;
    r_next   = r_reg;

    // pin synchronisers, first stage feeds only the second
    r_next.kbd_s   = {r_reg.kbd_s[1:0], kbd_activity};
    r_next.mouse_s = {r_reg.mouse_s[1:0], mouse_activity};
    r_next.strap_s = {r_reg.strap_s[0], expiry_action_strap};
    kbd_evt = r_reg.kbd_s[1] && !r_reg.kbd_s[2];
    ms_evt  = r_reg.mouse_s[1] && !r_reg.mouse_s[2];

    // strap caught once the synchroniser has filled after reset
    if (!r_reg.strap_done) begin
      if (r_reg.strap_wait == IWDT_STRAP_WAIT) begin
        r_next.strap_irq  = r_reg.strap_s[1];
        r_next.strap_done = 1'b1;
      end else begin
        r_next.strap_wait = r_reg.strap_wait + 2'h1;
      end
    end

    // port decode
    idx_wr = io_req.wr && (io_req.addr == IWDT_INDEX_PORT);
    dat_wr = io_req.wr && (io_req.addr == IWDT_DATA_PORT);
    idx_rd = io_req.rd && (io_req.addr == IWDT_INDEX_PORT);
    dat_rd = io_req.rd && (io_req.addr == IWDT_DATA_PORT);
    open_cfg = (r_reg.cfg == IWDT_UNLOCKED);

    // lock sequence; a broken key pair starts over
    unique case (r_reg.cfg)
      IWDT_LOCKED: begin
        if (idx_wr && io_req.wdata == IWDT_KEY_UNLOCK) begin
          r_next.cfg = IWDT_KEY_ONE;
        end
      end
      IWDT_KEY_ONE: begin
        if (idx_wr && io_req.wdata == IWDT_KEY_UNLOCK) begin
          r_next.cfg = IWDT_UNLOCKED;
        end else if (idx_wr || dat_wr || dat_rd) begin
          r_next.cfg = IWDT_LOCKED;
        end
      end
      IWDT_UNLOCKED: begin
        if (idx_wr && io_req.wdata == IWDT_KEY_LOCK) begin
          r_next.cfg = IWDT_LOCKED;
        end else if (idx_wr) begin
          r_next.index = io_req.wdata;
        end
      end
      default: begin
        r_next.cfg = IWDT_LOCKED; // illegal code recovers locked
      end
    endcase

    // data writes act only while unlocked
    if (dat_wr && open_cfg) begin
      if (r_reg.index == IWDT_IDX_DEV_SELECT) begin
        r_next.dev_sel = io_req.wdata;
      end else if (wdt_bank(r_reg.dev_sel)) begin
        unique case (r_reg.index)
          IWDT_IDX_ACTIVATE: begin
            r_next.active = io_req.wdata[IWDT_ACT_BIT];
          end
          IWDT_IDX_UNIT: begin
            r_next.unit_min = io_req.wdata[IWDT_UNIT_BIT];
          end
          IWDT_IDX_COUNT: begin
            r_next.count_set = io_req.wdata;
            cnt_wr = 1'b1;
          end
          IWDT_IDX_CTRL: begin
            r_next.kbd_en   = io_req.wdata[IWDT_KBD_BIT];
            r_next.mouse_en = io_req.wdata[IWDT_MOUSE_BIT];
            force_to        = io_req.wdata[IWDT_FORCE_BIT];
          end
          default: begin
            r_next.index = r_reg.index; // unmapped, ignored
          end
        endcase
      end
    end

    // restart sources, each reloads from the programmed count
    restart = cnt_wr
              || (kbd_evt && r_reg.kbd_en)
              || (ms_evt && r_reg.mouse_en);
    if (restart) begin
      r_next.counter   = cnt_wr ? io_req.wdata : r_reg.count_set;
      r_next.timed_out = 1'b0;
    end else if (unit_tick && run) begin
      r_next.counter = r_reg.counter - IWDT_ONE8;
    end

    // expiry, placed after the clear so a set always wins
    if (unit_tick && run && r_reg.counter == IWDT_ONE8) begin
      r_next.timed_out = 1'b1;
    end
    if (force_to) begin
      r_next.timed_out = 1'b1;
    end

    // expiry routed by the strap; nothing leaves before capture
    r_next.irq_n = !(r_next.timed_out && r_next.strap_irq
                     && r_next.strap_done);
    r_next.rst_out = r_next.timed_out && !r_next.strap_irq
                     && r_next.strap_done;

    // read answer one cycle after the strobe
    r_next.rvalid = idx_rd || dat_rd;
    if ((idx_rd || dat_rd) && !open_cfg) begin
      r_next.rdata = IWDT_READ_IDLE;
    end else if (idx_rd) begin
      r_next.rdata = r_reg.index;
    end else if (dat_rd) begin
      r_next.rdata = reg_read(r_reg);
    end
  end

  // -------------------------------------------------------------
  // state register
  // -------------------------------------------------------------
  // reset leaves the watchdog disabled, counting seconds, stopped
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      r_reg            <= '0;
      r_reg.cfg        <= IWDT_LOCKED;
      r_reg.active     <= 1'b0;
      r_reg.unit_min   <= 1'b0;
      r_reg.count_set  <= IWDT_ZERO8;
      r_reg.kbd_en     <= 1'b0;
      r_reg.rdata      <= IWDT_READ_IDLE;
      r_reg.irq_n      <= 1'b1;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // -------------------------------------------------------------
  // outputs, all straight from flops
  // -------------------------------------------------------------
  assign io_rdata      = r_reg.rdata;
  assign io_rvalid     = r_reg.rvalid;
  assign timeout_irq_n = r_reg.irq_n;
  assign timeout_reset = r_reg.rst_out;

endmodule // iwdt_top

// ===== verification/iwdt_properties.sv
// iwdt_properties: port-level checks of the indexed-port watchdog
// assumes one clk domain, async active-high reset, strap moved only in reset
`timescale 1ns/1ns
module iwdt_checker (
  // clock and reset
  input wire logic                   clk,
  input wire logic                   reset,
  input wire logic                   ce,
  // host io port
  input wire iwdt_pkg::iwdt_io_req_t io_req,
  input wire logic [7:0]             io_rdata,
  input wire logic                   io_rvalid,
  // pins
  input wire logic                   kbd_activity,
  input wire logic                   mouse_activity,
  input wire logic                   expiry_action_strap,
  input wire logic                   timeout_irq_n,
  input wire logic                   timeout_reset
);
  import iwdt_pkg::*;
  logic [3:0] act_reg; // recent pin activity, covers the sync delay
  logic       key_reg; // one unlock key seen
  logic       unl_reg; // session unlocked
  logic       rdl_reg; // last read made while locked
  wire idx_wr = ce & io_req.wr & (io_req.addr == IWDT_INDEX_PORT);
  wire dat_ac = ce & (io_req.wr | io_req.rd) & (io_req.addr == IWDT_DATA_PORT);
  wire io_rd  = ce & io_req.rd & ((io_req.addr == IWDT_INDEX_PORT) | (io_req.addr == IWDT_DATA_PORT));
  wire quiet  = (act_reg == 4'h0) & !kbd_activity & !mouse_activity;

  // shadow of the key sequence, so locked reads can be judged
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      act_reg <= 4'h0;
      key_reg <= 1'b0;
      unl_reg <= 1'b0;
      rdl_reg <= 1'b0;
    end else if (ce) begin
      act_reg <= {act_reg[2:0], kbd_activity | mouse_activity};
      if (io_rd) begin
        rdl_reg <= !unl_reg;
      end
      if (idx_wr && unl_reg) begin
        unl_reg <= (io_req.wdata != IWDT_KEY_LOCK);
      end else if (idx_wr) begin
        unl_reg <= key_reg & (io_req.wdata == IWDT_KEY_UNLOCK);
        key_reg <= !key_reg & (io_req.wdata == IWDT_KEY_UNLOCK);
      end else if (dat_ac) begin
        key_reg <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_rd_answer; io_rd |=> io_rvalid; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered next cycle");
  property p_rv_cause; io_rvalid |-> $past(io_rd); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("read valid without a port read");
  property p_rdata_hold; !io_rvalid |-> $stable(io_rdata); endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without valid");
  property p_locked_read; io_rvalid && rdl_reg |-> io_rdata == IWDT_READ_IDLE; endproperty
  a_locked_read: assert property (p_locked_read) else $error("locked read returned data");
  property p_one_form; !(!timeout_irq_n && timeout_reset); endproperty
  a_one_form: assert property (p_one_form) else $error("both expiry outputs asserted");
  property p_irq_strap; !timeout_irq_n |-> expiry_action_strap; endproperty
  a_irq_strap: assert property (p_irq_strap) else $error("interrupt with reset strap");
  property p_rst_strap; timeout_reset |-> !expiry_action_strap; endproperty
  a_rst_strap: assert property (p_rst_strap) else $error("reset with interrupt strap");
  property p_irq_hold; !timeout_irq_n && !io_req.wr && quiet |=> !timeout_irq_n; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("interrupt released without restart");
  property p_rst_hold; timeout_reset && !io_req.wr && quiet |=> timeout_reset; endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("reset released without restart");
endmodule // iwdt_checker

bind iwdt_top iwdt_checker chk_u (.clk(clk), .reset(reset), .ce(ce), .io_req(io_req), .io_rdata(io_rdata),
  .io_rvalid(io_rvalid), .kbd_activity(kbd_activity), .mouse_activity(mouse_activity),
  .expiry_action_strap(expiry_action_strap), .timeout_irq_n(timeout_irq_n), .timeout_reset(timeout_reset));

// ===== verification/iwdt_host_model.sv
// iwdt_host_model: host software side of the index/data io port pair
// assumes strobes launched just after a rising clk edge, one cycle long
`timescale 1ns/1ns
module iwdt_host_model (
  // clock
  input wire logic                   clk,
  // io port
  output iwdt_pkg::iwdt_io_req_t     io_req,
  input wire logic [7:0]             io_rdata,
  input wire logic                   io_rvalid
);
  import iwdt_pkg::*;
  initial io_req = '{16'h0000, 1'b0, 1'b0, 8'h00};

  // one strobe; released bus shows the inverse, never the old value
  task automatic strobe(input logic [15:0] a, input logic w, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{a, w, !w, d};
    @(posedge clk);
    io_req <= '{~a, 1'b0, 1'b0, ~d};
  endtask
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    strobe(a, 1'b1, d);
  endtask
  // read answer waited for a bounded few cycles
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    int n;
    d = 'x;
    n = 0;
    strobe(a, 1'b0, 8'h00);
    do begin
      @(posedge clk);
      n++;
    end while (io_rvalid !== 1'b1 && n < 4);
    if (io_rvalid === 1'b1) d = io_rdata;
  endtask
  task automatic wr_reg(input logic [7:0] idx, input logic [7:0] v);
    io_wr(IWDT_INDEX_PORT, idx);
    io_wr(IWDT_DATA_PORT, v);
  endtask
  task automatic rd_reg(input logic [7:0] idx, output logic [7:0] v);
    io_wr(IWDT_INDEX_PORT, idx);
    io_rd(IWDT_DATA_PORT, v);
  endtask
  task automatic unlock;
    io_wr(IWDT_INDEX_PORT, IWDT_KEY_UNLOCK);
    io_wr(IWDT_INDEX_PORT, IWDT_KEY_UNLOCK);
  endtask
  task automatic lock;
    io_wr(IWDT_INDEX_PORT, IWDT_KEY_LOCK);
  endtask
endmodule // iwdt_host_model

// ===== verification/indexed_port_watchdog_timer_tb.sv
// indexed_port_watchdog_timer_tb: register model and timer checks
// assumes a short second of CPS cycles; strap only moved under reset
`timescale 1ns/1ns
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module indexed_port_watchdog_timer_tb;
  import iwdt_pkg::*;
  localparam int unsigned CPS = 10; // cycles per second in simulation
  logic clk, reset, ce, kbd_activity, mouse_activity, expiry_action_strap;
  iwdt_io_req_t io_req;
  logic [7:0] io_rdata, d;
  logic io_rvalid, timeout_irq_n, timeout_reset;
  int error_cnt, compares, n;
  int m_unl, m_dev, m_act, m_unit, m_cnt, m_ctrl, m_to; // behavioural register model
  int regs[5] = '{'h30, 'hF5, 'hF6, 'hF7, 'h55};
  int cnts[3];

  iwdt_top #(.CYC_PER_SEC(CPS)) dut_u (.clk(clk), .reset(reset), .ce(ce), .io_req(io_req), .io_rdata(io_rdata),
    .io_rvalid(io_rvalid), .kbd_activity(kbd_activity), .mouse_activity(mouse_activity),
    .expiry_action_strap(expiry_action_strap), .timeout_irq_n(timeout_irq_n), .timeout_reset(timeout_reset));
  iwdt_host_model host_u (.clk(clk), .io_req(io_req), .io_rdata(io_rdata), .io_rvalid(io_rvalid));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // expected read value from the model
  function automatic logic [7:0] exp_rd(input int idx);
    if (m_unl == 0) return IWDT_READ_IDLE;
    if (m_dev != 8) return 8'h00;
    case (idx)
      'h30: return 8'(m_act);
      'hF5: return 8'(m_unit);
      'hF6: return 8'(m_cnt);
      'hF7: return 8'(m_ctrl | (m_to << 4));
      default: return 8'h00;
    endcase
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic hw_reset(input logic s);
    @(posedge clk);
    reset <= 1'b1;
    expiry_action_strap <= s;
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    {m_unl, m_dev, m_act, m_unit, m_cnt, m_ctrl, m_to} = '0;
    cyc(4); // strap sync fill
  endtask
  task automatic wreg(input int idx, input int v);
    host_u.wr_reg(8'(idx), 8'(v));
    if (m_unl == 0 || (m_dev != 8 && idx != 7)) return;
    case (idx)
      7: m_dev = v;
      'h30: m_act = v & 1;
      'hF5: m_unit = v & 8;
      'hF6: begin
        m_cnt = v;
        m_to = 0;
      end
      'hF7: begin m_ctrl = v & 'hC0; if (v & 'h20) m_to = 1; end
      default: ;
    endcase
  endtask
  task automatic rreg(input int idx);
    host_u.rd_reg(8'(idx), d);
    `CHK(d, exp_rd(idx))
  endtask
  // expiry expected in a narrow window around k cycles
  task automatic expect_expiry(input int k);
    cyc(k - 3);
    `CHK(timeout_irq_n, 1'b1)
    cyc(7);
    `CHK(timeout_irq_n, 1'b0)
    m_to = 1;
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    if (i == 0) kbd_activity <= 1'b1; else mouse_activity <= 1'b1;
    repeat (3) @(posedge clk);
    kbd_activity <= 1'b0;
    mouse_activity <= 1'b0;
    cyc(8);
  endtask
  task automatic conclude;
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard, well beyond the expected few thousand cycles
  initial begin
    #80000;
    error_cnt++;
    conclude();
  end

  initial begin
    reset = 1'b1; ce = 1'b1; kbd_activity = 1'b0; mouse_activity = 1'b0; expiry_action_strap = 1'b1;
    error_cnt = 0; compares = 0;
    void'($urandom(56));
    hw_reset(1'b1);
    `CHK(timeout_irq_n, 1'b1)
    rreg('hF6);
    host_u.io_wr(IWDT_INDEX_PORT, IWDT_KEY_UNLOCK);
    host_u.io_wr(IWDT_DATA_PORT, 8'h08);
    host_u.io_wr(IWDT_INDEX_PORT, IWDT_KEY_UNLOCK);
    rreg('hF6);
    host_u.unlock();
    m_unl = 1;
    wreg(7, 3);
    rreg('hF6);
    wreg(7, 8);
    foreach (regs[i]) rreg(regs[i]);
    // seconds mode: smallest, largest and a random count
    wreg('h30, 1);
    n = 2 + ($urandom % 4);
    cnts = '{1, 'hFF, n};
    foreach (cnts[i]) begin
      wreg('hF6, cnts[i]);
      expect_expiry(cnts[i] * CPS);
    end
    rreg('hF7);
    cyc(20);
    `CHK(timeout_irq_n, 1'b0)
    wreg('hF6, n);
    cyc(n * CPS - 8);
    wreg('hF6, n);
    // clock enable low for 20 edges must push expiry out by 20
    @(posedge clk);
    ce <= 1'b0;
    repeat (20) @(posedge clk);
    ce <= 1'b1;
    expect_expiry(n * CPS);
    wreg('hF6, 0);
    cyc(100);
    `CHK(timeout_irq_n, 1'b1)
    wreg('hF6, 2);
    wreg('h30, 0);
    cyc(40);
    `CHK(timeout_irq_n, 1'b1)
    wreg('h30, 1);
    wreg('hF6, 0);
    // forced expiry, then keyboard and mouse restarts
    for (int i = 0; i < 2; i++) begin
      wreg('hF7, 'h20);
      cyc(2);
      `CHK(timeout_irq_n, 1'b0)
      rreg('hF7);
      pulse(i);
      `CHK(timeout_irq_n, 1'b0)
      wreg('hF7, 'h40 << i);
      pulse(i);
      m_to = 0;
      `CHK(timeout_irq_n, 1'b1)
      rreg('hF7);
    end
    wreg('hF5, 8);
    rreg('hF5);
    wreg('hF6, 1);
    expect_expiry(60 * CPS);
    host_u.lock();
    m_unl = 0;
    rreg('hF6);
    wreg('hF6, 5);
    host_u.unlock();
    m_unl = 1;
    rreg('hF6);
    hw_reset(1'b0);
    host_u.unlock();
    m_unl = 1;
    wreg(7, 8);
    wreg('hF7, 'h20);
    cyc(2);
    `CHK(timeout_reset, 1'b1)
    `CHK(timeout_irq_n, 1'b1)
    conclude();
  end
endmodule // indexed_port_watchdog_timer_tb
